/* cyl_select_map.svh */
// Constants for the cylinder address and drive select logic
`ifndef CYL_SELECT_MAP_SVH
`define CYL_SELECT_MAP_SVH

// Cylinder address width and highest valid cylinder
`define CYL_ADDR_W 9
`define CYL_MAX_VALID 9'h197

// Cylinder register value after reset or return to zero
`define CYL_RESET_VAL 9'h000

// Bit positions in the synchronised pin bundle
`define PIN_ADDR_LSB 0
`define PIN_LOAD 9
`define PIN_PICK_A 10
`define PIN_PICK_B 11
`define PIN_PLATTER 12
`define PIN_RESTORE 13
`define PIN_W 14

// Idle level of every active low pin
`define PIN_IDLE 14'h3fff

// Synchroniser depth
`define SYNC_STAGES 3

`endif

/* cyl_select_pkg.sv */
// Types for the cylinder address and drive select logic
package cyl_select_pkg;

  // Gray coded handshake states
  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_capture = 2'b01,
    st_acked   = 2'b11,
    st_reject  = 2'b10
  } hs_state_t;

endpackage

/* pin_bundle_if.sv */
// Carrier between the pin synchroniser and the core logic
`timescale 1ns/1ps
`default_nettype none

interface pin_bundle_if #(
  parameter int W = 14
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport sync_side (input raw, output clean);
  modport core_side (output raw, input clean);
endinterface

`default_nettype wire

/* pin_sync.sv */
// Three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

`include "cyl_select_map.svh"

module pin_sync #(
  parameter int W = 14,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clock_in,  // System clock
  input wire logic rst_in,    // Synchronous reset, high
  pin_bundle_if.sync_side pins // Raw in, filtered out
);

  // ------------------------------------------------------------
  // Per bit chain
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [`SYNC_STAGES-1:0] chain;
      logic held;
      wire agree = (chain[1] == chain[2]);
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          chain <= {`SYNC_STAGES{IDLE[i]}};
          held <= IDLE[i];
        end else begin
          chain <= {chain[1:0], pins.raw[i]};
          if (agree) begin
            held <= chain[2];
          end
        end
      end
      assign pins.clean[i] = held;
    end
  endgenerate

endmodule

`default_nettype wire

/* disk_cylinder_address_select.sv */
// Drive side cylinder address capture, acknowledge and drive select logic
// Overview of operation
// - Every interface line counts as asserted when low unless stated otherwise.
// - The drive captures the address lines whenever the address strobe is low and return to zero is not.
// - The drive is selected only while its select line is low and holds two logical units.
// - An unselected drive ignores all control inputs.
// - An unselected drive drives no status output except seek fault and unit ready.
// - The drive acknowledges a valid address and treats any cylinder above 407 as invalid.
// - Platter select low picks the fixed platter and high picks the removable one.
// - Return to zero is taken only while the strobe is low and clears address and faults.
`timescale 1ns/1ps
`default_nettype none

`include "cyl_select_map.svh"

module disk_cylinder_address_select
  import cyl_select_pkg::*;
#(
  parameter int CYL_W = `CYL_ADDR_W,
  parameter bit DRIVE_IS_B = 1'b0
) (
  input wire logic clock_in,                  // System clock, 100 MHz
  input wire logic rst_in,                    // Synchronous reset, high
  input wire logic [CYL_W-1:0] cyl_addr_n_in, // Cylinder address pins, bit 0 weight 1
  input wire logic cyl_addr_load_n_in,        // Address strobe pin
  input wire logic drive_a_pick_n_in,         // Drive A select pin
  input wire logic drive_b_pick_n_in,         // Drive B select pin
  input wire logic platter_pick_n_in,         // Platter select pin
  input wire logic restore_n_in,              // Return to zero pin
  input wire logic seek_fail_in,              // Mechanism reports failed seek
  input wire logic unit_ready_in,             // Mechanism reports unit ready
  output logic cyl_addr_accepted_n_out,       // Address acknowledge pin level
  output logic cyl_addr_accepted_oe_n_out,    // Acknowledge pin enable, low drives
  output logic seek_fault_n_out,              // Seek fault pin, always driven
  output logic unit_ready_n_out,              // Unit ready pin, always driven
  output logic [CYL_W-1:0] target_cyl_out,    // Held cylinder address
  output logic seek_req_out,                  // Pulse: start seek to target
  output logic restore_req_out,               // Pulse: return to track zero
  output logic addr_invalid_out,              // Strobed address out of range
  output logic selected_out,                  // This drive is selected
  output logic platter_fixed_out,             // Fixed platter chosen
  output logic [1:0] logical_unit_out         // Addressed logical unit
);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  generate
    if (CYL_W != `CYL_ADDR_W) begin : g_bad_width
      $error("cylinder address width must be nine bits");
    end
  endgenerate

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  pin_bundle_if #(.W(`PIN_W)) pins ();

  assign pins.raw = {restore_n_in, platter_pick_n_in, drive_b_pick_n_in,
                     drive_a_pick_n_in, cyl_addr_load_n_in, cyl_addr_n_in};

  pin_sync #(
    .W(`PIN_W),
    .IDLE(`PIN_IDLE)
  ) u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pins(pins)
  );

  // ------------------------------------------------------------
  // Pin decode, all lines asserted low
  // ------------------------------------------------------------
  wire [CYL_W-1:0] addr_val = ~pins.clean[`PIN_ADDR_LSB +: CYL_W];
  wire strobe = ~pins.clean[`PIN_LOAD];
  wire pick_a = ~pins.clean[`PIN_PICK_A];
  wire pick_b = ~pins.clean[`PIN_PICK_B];
  wire platter_low = ~pins.clean[`PIN_PLATTER];
  wire restore = ~pins.clean[`PIN_RESTORE];

  // Selected only while own line is low
  wire sel = DRIVE_IS_B ? pick_b : pick_a;

  // Control inputs count only when selected
  wire sel_strobe = sel & strobe;
  wire sel_restore = sel & restore;

  // Range check on the presented cylinder
  wire addr_ok = (addr_val <= `CYL_MAX_VALID);

  // ------------------------------------------------------------
  // Return to zero
  // ------------------------------------------------------------
  logic restore_seen;

  // Taken only with strobe low, once per assertion
  wire restore_take = sel_restore & strobe & ~restore_seen;

  // Restore holds off capture while it is asserted
  wire restore_busy = sel_restore & strobe;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      restore_seen <= 1'b0;
    end else begin
      restore_seen <= sel_restore & strobe;
    end
  end

  // ------------------------------------------------------------
  // Address capture
  // ------------------------------------------------------------
  logic [CYL_W-1:0] cyl_reg;

  wire capture = sel_strobe & ~restore_busy;

  wire [CYL_W-1:0] next_cyl = restore_take ? `CYL_RESET_VAL :
                              capture ? addr_val :
                              cyl_reg;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cyl_reg <= `CYL_RESET_VAL;
    end else begin
      cyl_reg <= next_cyl;
    end
  end

  // ------------------------------------------------------------
  // Strobe handshake
  // ------------------------------------------------------------
  hs_state_t state;
  hs_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (capture) begin
          next_state = st_capture;
        end
      end
      st_capture: begin
        if (!capture) begin
          next_state = st_idle;
        end else if (addr_ok) begin
          next_state = st_acked;
        end else begin
          next_state = st_reject;
        end
      end
      st_acked: begin
        if (!capture) begin
          next_state = st_idle;
        end else if (!addr_ok) begin
          next_state = st_reject;
        end
      end
      st_reject: begin
        if (!capture) begin
          next_state = st_idle;
        end else if (addr_ok) begin
          next_state = st_acked;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  wire ack_now = (next_state == st_acked);
  wire ack_rise = ack_now & (state != st_acked);

  // ------------------------------------------------------------
  // Seek fault latch, set wins over restore clear
  // ------------------------------------------------------------
  logic fault;

  wire next_fault = seek_fail_in | (fault & ~restore_take);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fault <= 1'b0;
    end else begin
      fault <= next_fault;
    end
  end

  // ------------------------------------------------------------
  // Logical unit decode
  // ------------------------------------------------------------
  // Low platter line picks the fixed platter
  wire fixed_pick = platter_low;

  // Drive A gives units 0 and 1, drive B units 2 and 3
  wire [1:0] next_unit = {DRIVE_IS_B, ~fixed_pick};

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cyl_addr_accepted_n_out <= 1'b1;
      cyl_addr_accepted_oe_n_out <= 1'b1;
      seek_fault_n_out <= 1'b1;
      unit_ready_n_out <= 1'b1;
      target_cyl_out <= `CYL_RESET_VAL;
      seek_req_out <= 1'b0;
      restore_req_out <= 1'b0;
      addr_invalid_out <= 1'b0;
      selected_out <= 1'b0;
      platter_fixed_out <= 1'b0;
      logical_unit_out <= 2'h0;
    end else begin
      cyl_addr_accepted_n_out <= ~(ack_now & sel);
      cyl_addr_accepted_oe_n_out <= ~sel;
      seek_fault_n_out <= ~next_fault;
      unit_ready_n_out <= ~(unit_ready_in & ~next_fault);
      target_cyl_out <= next_cyl;
      seek_req_out <= ack_rise;
      restore_req_out <= restore_take;
      addr_invalid_out <= (next_state == st_reject);
      selected_out <= sel;
      platter_fixed_out <= sel ? fixed_pick : platter_fixed_out;
      logical_unit_out <= sel ? next_unit : logical_unit_out;
    end
  end

endmodule

`default_nettype wire

/* cyl_sel_props.sv */
// Checker for the cylinder address capture, acknowledge and select outputs
`timescale 1ns/1ps
`default_nettype none
module cyl_sel_props #(
  parameter bit DRIVE_IS_B = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [8:0] cyl_addr_n_in,
  input wire logic cyl_addr_load_n_in,
  input wire logic drive_a_pick_n_in,
  input wire logic drive_b_pick_n_in,
  input wire logic platter_pick_n_in,
  input wire logic restore_n_in,
  input wire logic seek_fail_in,
  input wire logic unit_ready_in,
  input wire logic cyl_addr_accepted_n_out,
  input wire logic cyl_addr_accepted_oe_n_out,
  input wire logic seek_fault_n_out,
  input wire logic unit_ready_n_out,
  input wire logic [8:0] target_cyl_out,
  input wire logic seek_req_out,
  input wire logic restore_req_out,
  input wire logic addr_invalid_out,
  input wire logic selected_out,
  input wire logic platter_fixed_out,
  input wire logic [1:0] logical_unit_out
);
  // ----------------------------------------
  // Cycles since strobe and own select low
  // ----------------------------------------
  logic [3:0] since_load;
  wire own_pick_n = DRIVE_IS_B ? drive_b_pick_n_in : drive_a_pick_n_in;
  always_ff @(posedge clock_in) begin
    if (rst_in || (!cyl_addr_load_n_in && !own_pick_n)) since_load <= rst_in ? 4'hf : 4'h0;
    else if (since_load != 4'hf) since_load <= since_load + 4'h1;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_seek_pulse: assert property (seek_req_out |=> !seek_req_out) else $error("seek pulse too long");
  a_seek_acked: assert property (seek_req_out |-> !cyl_addr_accepted_n_out && !addr_invalid_out)
    else $error("seek without acknowledge");
  a_ack_range: assert property ($fell(cyl_addr_accepted_n_out) |-> target_cyl_out <= 9'h197)
    else $error("acknowledge of invalid cylinder");
  a_ack_select: assert property (!cyl_addr_accepted_n_out |-> selected_out || $past(selected_out))
    else $error("acknowledge while unselected");
  a_drive_sel: assert property (selected_out ##1 selected_out |-> !cyl_addr_accepted_oe_n_out)
    else $error("acknowledge pin not driven");
  a_float_unsel: assert property (!selected_out ##1 !selected_out |-> cyl_addr_accepted_oe_n_out)
    else $error("acknowledge pin driven while unselected");
  a_target_held: assert property ($changed(target_cyl_out) |-> since_load < 4'ha)
    else $error("target changed without strobe");
  a_restore_clear: assert property (restore_req_out |=> !restore_req_out && target_cyl_out == 9'h000)
    else $error("restore did not clear target");
  a_unit_map: assert property (selected_out |=> logical_unit_out == {DRIVE_IS_B, !platter_fixed_out})
    else $error("logical unit mismatch");
  a_fault_set: assert property (seek_fail_in |=> !seek_fault_n_out) else $error("fault not shown");
  a_ready_drop: assert property (!unit_ready_in |=> unit_ready_n_out) else $error("ready stuck");
  a_invalid_noseek: assert property (addr_invalid_out |-> !seek_req_out) else $error("seek on invalid");
  c_seek: cover property (seek_req_out);
  c_restore: cover property (restore_req_out);
  c_invalid: cover property (addr_invalid_out);
endmodule
bind disk_cylinder_address_select cyl_sel_props #(.DRIVE_IS_B(DRIVE_IS_B)) i_props (.clock_in, .rst_in,
  .cyl_addr_n_in, .cyl_addr_load_n_in, .drive_a_pick_n_in, .drive_b_pick_n_in, .platter_pick_n_in,
  .restore_n_in, .seek_fail_in, .unit_ready_in, .cyl_addr_accepted_n_out, .cyl_addr_accepted_oe_n_out,
  .seek_fault_n_out, .unit_ready_n_out, .target_cyl_out, .seek_req_out, .restore_req_out,
  .addr_invalid_out, .selected_out, .platter_fixed_out, .logical_unit_out);
`default_nettype wire

/* ctl_model.sv */
// Controller model driving address, strobe, select and restore pins
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
  input wire logic clock_in,     // System clock
  input wire logic ack_n_in,     // Resolved acknowledge line
  output logic [8:0] addr_n_out, // Cylinder address pins
  output logic load_n_out,       // Address strobe
  output logic pick_a_n_out,     // Drive A select
  output logic pick_b_n_out,     // Drive B select
  output logic platter_n_out,    // Platter select
  output logic restore_n_out     // Return to zero
);
  // ----------------------------------------
  // Pin idle state and transfer tasks
  // ----------------------------------------
  initial begin
    addr_n_out = 9'h1ff;
    {load_n_out, pick_a_n_out, pick_b_n_out, platter_n_out, restore_n_out} = 5'h1f;
  end
  task automatic seek(input logic [8:0] cyl, input logic drv_b, input logic plat, input int hold,
                      output logic acked);
    int n;
    @(posedge clock_in);
    addr_n_out <= ~cyl;
    pick_a_n_out <= drv_b;
    pick_b_n_out <= !drv_b;
    platter_n_out <= plat;
    load_n_out <= 1'b0;
    n = 0;
    acked = 1'b0;
    while (!acked && n < 30) begin
      @(posedge clock_in);
      acked = (ack_n_in === 1'b0);
      n++;
    end
    repeat (hold) @(posedge clock_in);
    load_n_out <= 1'b1;
    addr_n_out <= cyl;
    {pick_a_n_out, pick_b_n_out} <= 2'h3;
    repeat (8) @(posedge clock_in);
  endtask
  task automatic restore(input logic with_strobe);
    @(posedge clock_in);
    pick_a_n_out <= 1'b0;
    load_n_out <= !with_strobe;
    restore_n_out <= 1'b0;
    repeat (100) @(posedge clock_in);
    {load_n_out, restore_n_out, pick_a_n_out} <= 3'h7;
    repeat (8) @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

/* disk_cylinder_address_select_tb.sv */
// Self-checking bench for the cylinder address select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module disk_cylinder_address_select_tb;
  logic clock_in, rst_in, seek_fail_in, unit_ready_in, load_n, pick_a_n, pick_b_n, platter_n, restore_n;
  logic acc_n, acc_oe_n, fault_n, rdy_n, seek_req, restore_req, invalid, sel, fixed, restore_seen;
  logic [8:0] addr_n, target, last;
  logic [1:0] unit;
  logic [11:0] expq[$];
  logic [11:0] exp_v;
  int n_errors = 0;
  int checks_done = 0;
  wire ack_line = acc_oe_n ? 1'b1 : acc_n;
  ctl_model i_ctl_model (.clock_in(clock_in), .ack_n_in(ack_line), .addr_n_out(addr_n), .load_n_out(load_n),
    .pick_a_n_out(pick_a_n), .pick_b_n_out(pick_b_n), .platter_n_out(platter_n), .restore_n_out(restore_n));
  disk_cylinder_address_select i_disk_cylinder_address_select (.clock_in(clock_in), .rst_in(rst_in),
    .cyl_addr_n_in(addr_n), .cyl_addr_load_n_in(load_n), .drive_a_pick_n_in(pick_a_n),
    .drive_b_pick_n_in(pick_b_n), .platter_pick_n_in(platter_n), .restore_n_in(restore_n),
    .seek_fail_in(seek_fail_in), .unit_ready_in(unit_ready_in), .cyl_addr_accepted_n_out(acc_n),
    .cyl_addr_accepted_oe_n_out(acc_oe_n), .seek_fault_n_out(fault_n), .unit_ready_n_out(rdy_n),
    .target_cyl_out(target), .seek_req_out(seek_req), .restore_req_out(restore_req),
    .addr_invalid_out(invalid), .selected_out(sel), .platter_fixed_out(fixed), .logical_unit_out(unit));
  // ----------------------------------------
  // Clock, watchdog and result monitor
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    #200000;
    n_errors++;
    results();
  end
  always @(negedge clock_in) begin
    restore_seen <= (restore_req === 1'b1);
    if (seek_req === 1'b1 || restore_seen) begin
      if (expq.size() == 0) begin
        n_errors++;
        $display("[ERR] result exp none got %h", target);
      end else begin
        exp_v = expq.pop_front();
        `CHK("result", exp_v, {restore_seen, restore_seen ? 2'b00 : unit, target})
      end
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_seek(input logic [8:0] cyl, input logic plat, input int hold);
    logic ok;
    if (cyl <= 9'h197) expq.push_back({2'b00, plat, cyl});
    fork
      i_ctl_model.seek(cyl, 1'b0, plat, hold, ok);
      begin
        repeat (7) @(posedge clock_in);
        @(negedge clock_in);
        `CHK("invalid", cyl > 9'h197, invalid)
        `CHK("selected", 1'b1, sel)
        `CHK("fixed", !plat, fixed)
      end
    join
    `CHK("ack", cyl <= 9'h197, ok)
    `CHK("held", cyl, target)
    last = cyl;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  logic [8:0] cyls[7] = '{9'h000, 9'h001, 9'h100, 9'h197, 9'h198, 9'h1ff, 9'h0aa};
  initial begin
    logic ok;
    rst_in = 1'b1;
    seek_fail_in = 1'b0;
    unit_ready_in = 1'b1;
    void'($urandom(32'h3b57));
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    foreach (cyls[i]) do_seek(cyls[i], i[0], i % 3);
    repeat (8) do_seek(9'($urandom % 408), 1'($urandom), int'($urandom % 3));
    $display("test seek done");
    i_ctl_model.seek(9'h055, 1'b1, 1'b0, 0, ok);
    `CHK("unsel ack", 1'b0, ok)
    `CHK("unsel target", last, target)
    `CHK("unsel enable", 1'b1, acc_oe_n)
    `CHK("unsel selected", 1'b0, sel)
    $display("test unselected done");
    @(posedge clock_in);
    seek_fail_in <= 1'b1;
    @(posedge clock_in);
    seek_fail_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    `CHK("fault", 1'b0, fault_n)
    `CHK("ready on fault", 1'b1, rdy_n)
    i_ctl_model.restore(1'b0);
    `CHK("restore no strobe", 1'b0, fault_n)
    expq.push_back(12'h800);
    i_ctl_model.restore(1'b1);
    `CHK("fault cleared", 1'b1, fault_n)
    `CHK("ready", 1'b0, rdy_n)
    $display("test restore done");
    unit_ready_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    `CHK("not ready", 1'b1, rdy_n)
    `CHK("drained", 0, expq.size())
    $display("test ready done");
    results();
  end
endmodule
`default_nettype wire
